//--- core/mppf_consts.vh
/*
  Constants for the multipurpose pin function and modulated output block:
  register offsets, field positions, reset values and function codes.
  Assumes it is included by bare name from the design file.
*/
`ifndef MPPF_CONSTS_VH
`define MPPF_CONSTS_VH

// ==================================================================
// Register offsets
`define MPPF_OFS_MOD_CTRL   8'h36
`define MPPF_OFS_PATTERN    8'h37
`define MPPF_OFS_PIN0_FUNC  8'h38
`define MPPF_OFS_PIN1_FUNC  8'h39

// ==================================================================
// Reset values
`define MPPF_RST_MOD_CTRL   8'h00
`define MPPF_RST_PATTERN    8'h00
`define MPPF_RST_PIN0_FUNC  8'h00
`define MPPF_RST_PIN1_FUNC  8'h10

// ==================================================================
// Field positions in modulated_output_control
`define MPPF_SEL_LSB        0
`define MPPF_SEL_MSB        1
`define MPPF_CH_LSB         2
`define MPPF_CH_MSB         3
`define MPPF_INS_BIT        4

// ==================================================================
// Output select and pattern channel codes
`define MPPF_SEL_OFF        2'h0
`define MPPF_SEL_LEFT       2'h1
`define MPPF_SEL_RIGHT      2'h2
`define MPPF_SEL_STEREO     2'h3
`define MPPF_CH_BOTH        2'h0
`define MPPF_CH_LEFT        2'h1
`define MPPF_CH_RIGHT       2'h2

// ==================================================================
// Pin function codes
`define MPPF_FN_SERIAL      5'h00
`define MPPF_FN_BANK        5'h0B
`define MPPF_FN_COMP        5'h0E
`define MPPF_FN_BYPASS      5'h0F
`define MPPF_FN_VOL_UP      5'h10
`define MPPF_FN_VOL_DN      5'h11
`define MPPF_FN_MOD_OUT     5'h12

// ==================================================================
// Pattern framing: last gap count (64 audio pairs per gap), last pattern bit index
`define MPPF_PAT_GAP        6'h3F
`define MPPF_PAT_LAST       3'h7

`endif

//--- core/mppf_top.v
/*
  Multipurpose pin function selection for the first two pins and the
  stereo modulated output stream with control pattern insertion, plus
  the sample FIFO in front of the stream serializer.
  Assumes one clock mclk, a synchronous active-low reset nrst, an
  audio core that supplies left/right modulated bits with valid/ready
  and consumes the mute and control levels, and a simple register port.
*/
`timescale 1ns/1ns
`include "mppf_consts.vh"

// ==================================================================
// Sample FIFO
module mppf_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg  [AW:0]      wptr_reg;        // Write pointer with wrap bit
  reg  [AW:0]      rptr_reg;        // Read pointer with wrap bit
  wire             full;
  wire             empty;
  wire             push;
  wire             pop;

  assign full      = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty     = (wptr_reg == rptr_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rptr_reg[AW-1:0]];

  // Memory write, no reset needed on data
  always @(posedge mclk)
  begin
    if (push)
    begin
      mem[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      wptr_reg <= {(AW+1){1'b0}};
      rptr_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule // mppf_fifo

// ==================================================================
// Top level
// Summary of operation
// - Select field: off, left, right, stereo
// - Insertion bit gates pattern into stream
// - Pattern channel: both, left, right; 11 reserved
// - Eight-bit pattern byte, reset zero
// - Pin zero code zero is playback data
// - Codes 8-10 mute playback converters
// - Bank, compression, bypass codes; 12,13 reserved
// - Codes 16,17 are volume up/down buttons
// - Pin one code zero is capture data
// - Pin one code 18 carries modulated output
// - Pin one function resets to 0x10
module mppf_top (
  input  wire       mclk,
  input  wire       nrst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       samp_left,
  input  wire       samp_right,
  input  wire       samp_valid,
  output wire       samp_ready,
  input  wire       playback_data_pin_i,
  output wire       playback_data_pin_o,
  output wire       playback_data_pin_oe_n,
  input  wire       capture_data_pin_i,
  output reg        capture_data_pin_o,
  output reg        capture_data_pin_oe_n,
  output reg        playback_sdata,
  input  wire       capture_sdata,
  output reg  [3:0] capture_mute,
  output reg  [1:0] playback_mute,
  output reg        bank_select,
  output reg        compress_enable,
  output reg        bypass_enable,
  output reg        vol_up,
  output reg        vol_down
);
  // State codes of the stream framer
  localparam ST_AUDIO   = 2'b01; // Audio pairs pass through
  localparam ST_PATTERN = 2'b10; // Pattern bits replace audio
  // Full-width reset value; only the low five bits are stored
  localparam [7:0] RST_MOD_CTRL = `MPPF_RST_MOD_CTRL;

  reg  [4:0] mod_ctrl_reg;     // Insert, channel, select
  reg  [7:0] pattern_reg;      // Control pattern byte
  reg  [7:0] pin0_func_reg;    // Pin zero function, reserved bits kept
  reg  [7:0] pin1_func_reg;    // Pin one function, reserved bits kept
  reg  [1:0] sync1_reg;        // First synchroniser stage
  reg  [1:0] sync2_reg;        // Second synchroniser stage
  reg  [1:0] state_reg;        // Framer state
  reg  [5:0] gap_reg;          // Audio pairs since last burst
  reg  [2:0] bit_idx_reg;      // Pattern bit index
  reg        phase_reg;        // 0 left slot, 1 right slot
  reg  [1:0] pair_reg;         // Held pair for right slot
  reg        mod_bit_reg;      // Serial modulated bit
  wire [1:0] sel;
  wire [1:0] ch;
  wire       ins;
  wire [1:0] fifo_data;
  wire       fifo_valid;
  wire       fifo_ready;
  wire       pop;
  wire [1:0] cur_pair;
  wire       pat_bit;
  wire [10:0] ctl0;
  wire [10:0] ctl1;
  wire [10:0] ctl_all;

  assign sel = mod_ctrl_reg[`MPPF_SEL_MSB:`MPPF_SEL_LSB];
  assign ch  = mod_ctrl_reg[`MPPF_CH_MSB:`MPPF_CH_LSB];
  assign ins = mod_ctrl_reg[`MPPF_INS_BIT];

  // Pin zero only ever listens, so it is never driven
  assign playback_data_pin_o    = 1'b0;
  assign playback_data_pin_oe_n = 1'b1;

  // ================================================================
  // Control decode shared by both pins
  // Bit order: cap_mute[3:0], pb_mute[5:4], bank, comp, byp, up, down
  function [10:0] ctl_decode;
    input [4:0] code;
    input       lvl;
    reg   [10:0] v;
    begin
      v = 11'h000;
      case (code)
        5'h01: v[0] = lvl;
        5'h02: v[1] = lvl;
        5'h03: v[2] = lvl;
        5'h04: v[3] = lvl;
        5'h05: v[1:0] = {2{lvl}};
        5'h06: v[3:2] = {2{lvl}};
        5'h07: v[3:0] = {4{lvl}};
        5'h08: v[4] = lvl;
        5'h09: v[5] = lvl;
        5'h0A: v[5:4] = {2{lvl}};
        `MPPF_FN_BANK:   v[6] = lvl;
        `MPPF_FN_COMP:   v[7] = lvl;
        `MPPF_FN_BYPASS: v[8] = lvl;
        `MPPF_FN_VOL_UP: v[9] = lvl;
        `MPPF_FN_VOL_DN: v[10] = lvl;
        default: v = 11'h000;
      endcase
      ctl_decode = v;
    end
  endfunction

  // ================================================================
  // Register port: writes and registered read data
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      mod_ctrl_reg  <= RST_MOD_CTRL[4:0];
      pattern_reg   <= `MPPF_RST_PATTERN;
      pin0_func_reg <= `MPPF_RST_PIN0_FUNC;
      pin1_func_reg <= `MPPF_RST_PIN1_FUNC;
      reg_rdata     <= 8'h00;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `MPPF_OFS_MOD_CTRL:  mod_ctrl_reg  <= reg_wdata[4:0];
          `MPPF_OFS_PATTERN:   pattern_reg   <= reg_wdata;
          `MPPF_OFS_PIN0_FUNC: pin0_func_reg <= reg_wdata;
          `MPPF_OFS_PIN1_FUNC: pin1_func_reg <= reg_wdata;
          default: ;                                        // Unmapped write ignored
        endcase
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `MPPF_OFS_MOD_CTRL:  reg_rdata <= {3'h0, mod_ctrl_reg};
          `MPPF_OFS_PATTERN:   reg_rdata <= pattern_reg;
          `MPPF_OFS_PIN0_FUNC: reg_rdata <= pin0_func_reg;
          `MPPF_OFS_PIN1_FUNC: reg_rdata <= pin1_func_reg;
          default:             reg_rdata <= 8'h00;         // Unmapped reads zero
        endcase
      end
    end
  end

  // ================================================================
  // Pin input synchronisers, two stages per pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      always @(posedge mclk)
      begin
        if (!nrst)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= (gi == 0) ? playback_data_pin_i : capture_data_pin_i;
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // ================================================================
  // Control outputs: both pins OR onto the same actions
  assign ctl0    = ctl_decode(pin0_func_reg[4:0], sync2_reg[0]);
  assign ctl1    = ctl_decode(pin1_func_reg[4:0], sync2_reg[1]);
  assign ctl_all = ctl0 | ctl1;

  // Registered control levels towards the audio core
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      capture_mute    <= 4'h0;
      playback_mute   <= 2'h0;
      bank_select     <= 1'b0;
      compress_enable <= 1'b0;
      bypass_enable   <= 1'b0;
      vol_up          <= 1'b0;
      vol_down        <= 1'b0;
      playback_sdata  <= 1'b0;
    end
    else
    begin
      capture_mute    <= ctl_all[3:0];
      playback_mute   <= ctl_all[5:4];
      bank_select     <= ctl_all[6];
      compress_enable <= ctl_all[7];
      bypass_enable   <= ctl_all[8];
      vol_up          <= ctl_all[9];
      vol_down        <= ctl_all[10];
      // Serial data passes only in the serial function
      playback_sdata  <= (pin0_func_reg[4:0] == `MPPF_FN_SERIAL) & sync2_reg[0];
    end
  end

  // ================================================================
  // Pin one output drive
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      capture_data_pin_o    <= 1'b0;
      capture_data_pin_oe_n <= 1'b1;
    end
    else
    begin
      case (pin1_func_reg[4:0])
        `MPPF_FN_SERIAL:
        begin
          capture_data_pin_o    <= capture_sdata;
          capture_data_pin_oe_n <= 1'b0;
        end
        `MPPF_FN_MOD_OUT:
        begin
          capture_data_pin_o    <= mod_bit_reg;
          capture_data_pin_oe_n <= 1'b0;
        end
        default:
        begin
          // Control and reserved codes release the pin
          capture_data_pin_o    <= 1'b0;
          capture_data_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ================================================================
  // Sample FIFO; stalls the core while the stream is off
  mppf_fifo #(
    .WIDTH (2),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_data   ({samp_left, samp_right}),
    .in_valid  (samp_valid),
    .in_ready  (samp_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // One pair taken per two cycles, at the left slot only
  assign fifo_ready = (sel != `MPPF_SEL_OFF) && !phase_reg;
  assign pop        = fifo_ready && fifo_valid;
  assign cur_pair   = phase_reg ? pair_reg : fifo_data;
  assign pat_bit    = pattern_reg[3'h7 - bit_idx_reg];

  // ================================================================
  // Slot bit selection with pattern overlay
  function slot_bit;
    input [1:0] s;
    input [1:0] c;
    input [1:0] pr;
    input       right;
    input       pat_on;
    input       pb;
    reg         b;
    begin
      case (s)
        `MPPF_SEL_LEFT:   b = pr[1];
        `MPPF_SEL_RIGHT:  b = pr[0];
        `MPPF_SEL_STEREO: b = right ? pr[0] : pr[1];
        default:          b = 1'b0;
      endcase
      // Reserved channel code inserts nothing
      if (pat_on && ((c == `MPPF_CH_BOTH) ||
                     (c == `MPPF_CH_LEFT && !right) ||
                     (c == `MPPF_CH_RIGHT && right)))
        b = pb;
      slot_bit = b;
    end
  endfunction

  // ================================================================
  // Stream framer and serializer
  // A burst of eight pattern pairs follows every gap of audio pairs;
  // underrun sends zero rather than repeating stale audio.
  always @(posedge mclk)
  begin
    if (!nrst || sel == `MPPF_SEL_OFF)
    begin
      state_reg   <= ST_AUDIO;
      gap_reg     <= 6'h00;
      bit_idx_reg <= 3'h0;
      phase_reg   <= 1'b0;
      pair_reg    <= 2'h0;
      mod_bit_reg <= 1'b0;
    end
    else if (!phase_reg)
    begin
      if (pop)
      begin
        pair_reg    <= fifo_data;
        phase_reg   <= 1'b1;
        mod_bit_reg <= slot_bit(sel, ch, cur_pair, 1'b0, (state_reg == ST_PATTERN), pat_bit);
      end
      else
      begin
        mod_bit_reg <= 1'b0;
      end
    end
    else
    begin
      phase_reg   <= 1'b0;
      mod_bit_reg <= slot_bit(sel, ch, cur_pair, 1'b1, (state_reg == ST_PATTERN), pat_bit);
      case (state_reg)
        ST_AUDIO:
        begin
          if (gap_reg == `MPPF_PAT_GAP)
          begin
            gap_reg <= 6'h00;
            if (ins)
              state_reg <= ST_PATTERN;
          end
          else
            gap_reg <= gap_reg + 6'h01;
        end
        ST_PATTERN:
        begin
          bit_idx_reg <= bit_idx_reg + 3'h1;
          if (bit_idx_reg == `MPPF_PAT_LAST || !ins)
          begin
            bit_idx_reg <= 3'h0;
            state_reg   <= ST_AUDIO;
          end
        end
        default:
          state_reg <= ST_AUDIO;
      endcase
    end
  end
endmodule // mppf_top

//--- dv/mppf_assertions.sv
/* Port checker for mppf_top.
   Assumes it is bound to mppf_top; it mirrors the code writes itself. */
`timescale 1ns/1ns
module mppf_chk (
  input wire       mclk,
  input wire       nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       playback_data_pin_i,
  input wire       playback_data_pin_oe_n,
  input wire       capture_data_pin_o,
  input wire       capture_data_pin_oe_n,
  input wire [3:0] capture_mute,
  input wire [1:0] playback_mute,
  input wire       bank_select,
  input wire       vol_down
);
  // ==========
  // Shadow codes, delayed a cycle to line up with the output register
  reg [4:0] a_reg, b_reg, da_reg, db_reg;
  reg [1:0] s_reg;
  reg [3:0] q_reg; // Cycles since last write, saturating
  always @(posedge mclk)
  begin
    da_reg <= a_reg;
    db_reg <= b_reg;
    if (!nrst)
    begin
      a_reg <= 5'h00;
      b_reg <= 5'h10;
      s_reg <= 2'h0;
      q_reg <= 4'h0;
    end
    else
    begin
      q_reg <= reg_wr ? 4'h0 : q_reg + {3'h0, q_reg != 4'hF};
      if (reg_wr && reg_addr == 8'h38) a_reg <= reg_wdata[4:0];
      if (reg_wr && reg_addr == 8'h39) b_reg <= reg_wdata[4:0];
      if (reg_wr && reg_addr == 8'h36) s_reg <= reg_wdata[1:0];
    end
  end
  // Code range test
  function automatic logic inr(logic [4:0] c, logic [4:0] lo, logic [4:0] hi);
    return c >= lo && c <= hi;
  endfunction
  // ==========
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_cmute; !inr(da_reg, 5'h01, 5'h07) && !inr(db_reg, 5'h01, 5'h07) |-> capture_mute == 4'h0; endproperty
  a_cmute: assert property (p_cmute) else $error("capture mute without code");
  property p_pmute; !inr(da_reg, 5'h08, 5'h0A) && !inr(db_reg, 5'h08, 5'h0A) |-> playback_mute == 2'h0; endproperty
  a_pmute: assert property (p_pmute) else $error("playback mute without code");
  property p_bank; bank_select |-> da_reg == 5'h0B || db_reg == 5'h0B; endproperty
  a_bank: assert property (p_bank) else $error("bank select without code");
  property p_vol; vol_down |-> da_reg == 5'h11 || db_reg == 5'h11; endproperty
  a_vol: assert property (p_vol) else $error("volume down without code");
  property p_drive; !capture_data_pin_oe_n |-> db_reg == 5'h00 || db_reg == 5'h12; endproperty
  a_drive: assert property (p_drive) else $error("pin one driven wrongly");
  property p_rsvd; inr(db_reg, 5'h0C, 5'h0D) || db_reg > 5'h12 |-> capture_data_pin_oe_n; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code drives pin");
  property p_pin0; playback_data_pin_oe_n; endproperty
  a_pin0: assert property (p_pin0) else $error("pin zero driven");
  property p_sync;
    q_reg > 4'h5 && da_reg == 5'h08 && !inr(db_reg, 5'h08, 5'h0A)
    && $past(playback_data_pin_i, 2) == $past(playback_data_pin_i, 3)
    && $past(playback_data_pin_i, 4) == $past(playback_data_pin_i, 5)
    && $past(playback_data_pin_i, 3) == $past(playback_data_pin_i, 4)
    |-> playback_mute[0] == $past(playback_data_pin_i, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("mute not following pin");
  property p_off; q_reg > 4'h9 && s_reg == 2'h0 && db_reg == 5'h12 |-> !capture_data_pin_o; endproperty
  a_off: assert property (p_off) else $error("output running while off");
  property p_rd; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  c_mod: cover property (s_reg == 2'h3 && !capture_data_pin_oe_n);
  c_mute: cover property (playback_mute[0]);
  c_vol: cover property (vol_down);
endmodule // mppf_chk

bind mppf_top mppf_chk mppf_chk_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .playback_data_pin_i, .playback_data_pin_oe_n, .capture_data_pin_o, .capture_data_pin_oe_n,
  .capture_mute, .playback_mute, .bank_select, .vol_down);

//--- dv/mppf_switch.sv
/* Board-side model of the two multipurpose pins: switches or a far device.
   Assumes the bench sets the switch levels; resolves each wire from enables. */
`timescale 1ns/1ns
module mppf_switch (
  input  wire lvl0,
  input  wire lvl1,
  input  wire pin0_o,
  input  wire pin0_oe_n,
  input  wire pin1_o,
  input  wire pin1_oe_n,
  output wire pin0,
  output wire pin1
);
  // ==========
  // Wire levels; switch levels are asynchronous to the block clock
  assign pin0 = pin0_oe_n ? lvl0 : pin0_o;
  // Block wins the wire while its enable is low
  assign pin1 = pin1_oe_n ? lvl1 : pin1_o;
endmodule // mppf_switch

//--- dv/mppf_top_tb.sv
/* Self-checking bench for mppf_top with the pin switch model.
   Assumes the 100 MHz clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module mppf_top_tb;
  logic       mclk, nrst, reg_wr, reg_rd, samp_left, samp_right, samp_valid, capture_sdata, l0, l1;
  logic [7:0] reg_addr, reg_wdata, d, v;
  wire  [7:0] reg_rdata;
  wire        samp_ready, playback_data_pin_i, playback_data_pin_o, playback_data_pin_oe_n;
  wire        capture_data_pin_i, capture_data_pin_o, capture_data_pin_oe_n, playback_sdata;
  wire  [3:0] capture_mute;
  wire  [1:0] playback_mute;
  wire        bank_select, compress_enable, bypass_enable, vol_up, vol_down;
  int         bad_count, checks_done, cyc, i, k;
  logic [31:0] rs = 32'h0BBC1799; // Fixed seed
  int          pm[5] = '{16, 8, 8, 0, 0}; // Pattern ones in one burst per channel code, last entry with insertion off
  wire [10:0]  obs = {capture_mute, playback_mute, bank_select, compress_enable, bypass_enable, vol_up, vol_down};
  mppf_top mppf_top_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .samp_left, .samp_right, .samp_valid, .samp_ready, .playback_data_pin_i, .playback_data_pin_o,
    .playback_data_pin_oe_n, .capture_data_pin_i, .capture_data_pin_o, .capture_data_pin_oe_n,
    .playback_sdata, .capture_sdata, .capture_mute, .playback_mute, .bank_select, .compress_enable,
    .bypass_enable, .vol_up, .vol_down);
  mppf_switch mppf_switch_i (.lvl0(l0), .lvl1(l1), .pin0_o(playback_data_pin_o),
    .pin0_oe_n(playback_data_pin_oe_n), .pin1_o(capture_data_pin_o), .pin1_oe_n(capture_data_pin_oe_n),
    .pin0(playback_data_pin_i), .pin1(capture_data_pin_i));
  // ==========
  // Clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  // ==========
  // Helpers
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Expected control outputs for a code and pin level
  function automatic logic [10:0] fx(logic [4:0] c, logic lv);
    logic [10:0] e;
    e = 11'h000;
    if (lv)
      case (c)
        5'h01, 5'h02, 5'h03, 5'h04: e[10:7] = 4'h1 << (c - 5'h01);
        5'h05: e[10:7] = 4'h3;
        5'h06: e[10:7] = 4'hC;
        5'h07: e[10:7] = 4'hF;
        5'h08: e[6:5] = 2'h1;
        5'h09: e[6:5] = 2'h2;
        5'h0A: e[6:5] = 2'h3;
        5'h0B: e[4] = 1'b1;
        5'h0E: e[3] = 1'b1;
        5'h0F: e[2] = 1'b1;
        5'h10: e[1] = 1'b1;
        5'h11: e[0] = 1'b1;
        default: e = 11'h000; // Reserved codes act on nothing
      endcase
    return e;
  endfunction
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] w);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] r);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    r = reg_rdata;
  endtask
  // Count high bits on the block's pin one output
  task ones(input int n, output int c);
    c = 0;
    repeat (n) @(negedge mclk) c += (capture_data_pin_o === 1'b1);
  endtask
  task wrap_up();
    $display("counts: %0d checks, %0d bad", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, samp_right, samp_valid, l0, l1, nrst} = 7'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    samp_left = 1'b1;
    capture_sdata = xs() & 32'h1;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    // Reset values, then write and read back; 0x3A lies outside the block
    for (i = 0; i < 5; i++)
    begin
      rd(8'h36 + i, d);
      chk("reset", i == 3 ? 8'h10 : 8'h00, d);
      v = xs();
      wr(8'h36 + i, v);
      rd(8'h36 + i, d);
      chk("readback", i == 0 ? v & 8'h1F : (i == 4 ? 8'h00 : v), d);
    end
    $display("test registers done");
    // Every code on each pin, the other pin parked on a reserved code
    wr(8'h39, 8'h0C);
    for (i = 0; i < 64; i++)
    begin
      v = xs();
      wr(i < 32 ? 8'h38 : 8'h39, i % 32);
      if (i < 32) l0 = v[0];
      else l1 = v[0];
      capture_sdata = v[1];
      repeat (6) @(negedge mclk);
      chk("controls", fx(i % 32, v[0]), obs);
      if (i < 32) chk("sdata0", i == 0 && v[0], playback_sdata);
      if (i < 32) chk("oe0", 16'h0002, {playback_data_pin_oe_n, playback_data_pin_o});
      if (i >= 32) chk("oe1", !(i == 32 || i == 50), capture_data_pin_oe_n);
      if (i == 32) chk("sdata1", capture_sdata, capture_data_pin_o);
      if (i == 31) wr(8'h38, 8'h0C);
    end
    $display("test pins done");
    // Output select with left 1, right 0
    wr(8'h39, 8'h12);
    samp_valid = 1'b1;
    for (i = 1; i < 4; i++)
    begin
      wr(8'h36, i);
      repeat (20) @(negedge mclk);
      ones(40, k);
      chk("select", i == 1 ? 40 : (i == 2 ? 0 : 20), k);
    end
    // Off: buffer fills and refuses; then drain it dry with input idle
    wr(8'h36, 8'h00);
    repeat (30) @(negedge mclk);
    chk("full", 1'b0, samp_ready);
    samp_valid = 1'b0;
    wr(8'h36, 8'h01);
    repeat (40) @(negedge mclk);
    ones(20, k);
    chk("empty", 0, k);
    $display("test stream done");
    // Pattern on each channel code, audio held at zero
    samp_left = 1'b0;
    samp_valid = 1'b1;
    wr(8'h36, 8'h00);
    wr(8'h37, 8'hFF);
    for (i = 0; i < 5; i++)
    begin
      wr(8'h36, 8'h00);
      wr(8'h36, i < 4 ? 8'h13 | (i << 2) : 8'h03);
      ones(200, k);
      chk("pattern", pm[i], k);
    end
    $display("test pattern done");
    wrap_up();
  end
endmodule // mppf_top_tb
